//--- rtl/bvp_top.sv
`timescale 1ns/100ps
`include "bvp_regs.svh"

// ----------------------------------------------------------------------
// ----------------------------------------------------------------------

module bvp_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // Register access
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // Legacy display side
    input  wire logic        latch_load_i,
    input  wire logic [31:0] latch_data_i,
    output logic      [31:0] legacy_base_o,
    output logic      [31:0] legacy_latch_o,
    // Expansion colours
    output logic      [15:0] colour_clear_o,
    output logic      [15:0] colour_set_o,
    // Engine status
    output logic             busy_o,
    output logic             op_line_o,
    output logic             op_done_o,
    // Pixel stream
    output logic             pix_valid_o,
    output logic      [15:0] pix_x_o,
    output logic      [15:0] pix_y_o,
    output logic      [15:0] pix_src_x_o,
    output logic      [15:0] pix_src_y_o
);

    // ------------------------------------------------------------------
    // Register file.
    // ------------------------------------------------------------------
    logic [31:0] origin_r,      origin_nxt;
    logic [31:0] size_r,        size_nxt;
    logic [31:0] source_r,      source_nxt;
    logic [31:0] colour_r,      colour_nxt;
    logic [31:0] line_mode_r,   line_mode_nxt;
    logic [31:0] block_mode_r,  block_mode_nxt;
    logic [23:0] stat_cfg_r,    stat_cfg_nxt;
    logic        drop_r,        drop_nxt;
    logic [31:0] legacy_base_r, legacy_base_nxt;
    logic [31:0] latch_r,       latch_nxt;
    logic [31:0] rdata_r,       rdata_nxt;
    logic        rvalid_r,      rvalid_nxt;
    logic        line_hit;
    logic        block_hit;
    logic        start_line;
    logic        start_block;
    logic        busy_r;

    always_comb begin
        line_hit  = reg_wr_i && (reg_addr_i == `BVP_OFS_LINE_TRIG);
        block_hit = reg_wr_i && (reg_addr_i == `BVP_OFS_BLOCK_TRIG);
        start_line  = line_hit && !busy_r;
        start_block = block_hit && !busy_r;
    end

    always_comb begin
        origin_nxt      = origin_r;
        size_nxt        = size_r;
        source_nxt      = source_r;
        colour_nxt      = colour_r;
        line_mode_nxt   = line_mode_r;
        block_mode_nxt  = block_mode_r;
        stat_cfg_nxt    = stat_cfg_r;
        drop_nxt        = drop_r;
        legacy_base_nxt = legacy_base_r;
        latch_nxt       = latch_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `BVP_OFS_ORIGIN:      origin_nxt = reg_wdata_i;
                `BVP_OFS_SIZE:        size_nxt = reg_wdata_i;
                `BVP_OFS_SOURCE:      source_nxt = reg_wdata_i;
                `BVP_OFS_COLOUR:      colour_nxt = reg_wdata_i;
                `BVP_OFS_LINE_TRIG:   line_mode_nxt = reg_wdata_i;
                `BVP_OFS_BLOCK_TRIG:  block_mode_nxt = reg_wdata_i;
                `BVP_OFS_STATUS: begin
                    stat_cfg_nxt = reg_wdata_i[`BVP_ST_CFG_MSB:
                                               `BVP_ST_CFG_LSB];
                    if (reg_wdata_i[`BVP_ST_DROP]) begin
                        drop_nxt = 1'b0;
                    end
                end
                `BVP_OFS_LEGACY_BASE:
                    legacy_base_nxt = reg_wdata_i;
                `BVP_OFS_LEGACY_LAT:  latch_nxt = reg_wdata_i;
                default: ;
            endcase
        end
        if ((line_hit || block_hit) && busy_r) begin
            drop_nxt = 1'b1;
        end
        if (latch_load_i) begin
            latch_nxt = latch_data_i;
        end
    end

    always_comb begin
        rvalid_nxt = reg_rd_i;
        rdata_nxt  = `BVP_RST_WORD;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `BVP_OFS_ORIGIN:      rdata_nxt = origin_r;
                `BVP_OFS_SIZE:        rdata_nxt = size_r;
                `BVP_OFS_SOURCE:      rdata_nxt = source_r;
                `BVP_OFS_COLOUR:      rdata_nxt = colour_r;
                `BVP_OFS_LINE_TRIG:   rdata_nxt = line_mode_r;
                `BVP_OFS_BLOCK_TRIG:  rdata_nxt = block_mode_r;
                `BVP_OFS_STATUS:      rdata_nxt = {stat_cfg_r, `BVP_ST_PAD,
                                                   drop_r, op_line_o,
                                                   busy_r};
                `BVP_OFS_LEGACY_BASE: rdata_nxt = legacy_base_r;
                `BVP_OFS_LEGACY_LAT:  rdata_nxt = latch_r;
                default:              rdata_nxt = `BVP_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            origin_r      <= `BVP_RST_WORD;
            size_r        <= `BVP_RST_WORD;
            source_r      <= `BVP_RST_WORD;
            colour_r      <= `BVP_RST_WORD;
            line_mode_r   <= `BVP_RST_WORD;
            block_mode_r  <= `BVP_RST_WORD;
            stat_cfg_r    <= 24'h00_0000;
            drop_r        <= 1'b0;
            legacy_base_r <= `BVP_RST_WORD;
            latch_r       <= `BVP_RST_WORD;
            rdata_r       <= `BVP_RST_WORD;
            rvalid_r      <= 1'b0;
        end else begin
            origin_r      <= origin_nxt;
            size_r        <= size_nxt;
            source_r      <= source_nxt;
            colour_r      <= colour_nxt;
            line_mode_r   <= line_mode_nxt;
            block_mode_r  <= block_mode_nxt;
            stat_cfg_r    <= stat_cfg_nxt;
            drop_r        <= drop_nxt;
            legacy_base_r <= legacy_base_nxt;
            latch_r       <= latch_nxt;
            rdata_r       <= rdata_nxt;
            rvalid_r      <= rvalid_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Drawing sequencer.
    // ------------------------------------------------------------------
    bvp_pkg::bvp_state_t state_r, state_nxt;
    logic [15:0] cur_x_r,  cur_x_nxt;
    logic [15:0] cur_y_r,  cur_y_nxt;
    logic [15:0] cur_sx_r, cur_sx_nxt;
    logic [15:0] cur_sy_r, cur_sy_nxt;
    logic [15:0] org_x_r,  org_x_nxt;
    logic [15:0] org_sx_r, org_sx_nxt;
    logic [15:0] width_r,  width_nxt;
    logic [15:0] height_r, height_nxt;
    logic [15:0] col_r,    col_nxt;
    logic [15:0] row_r,    row_nxt;
    logic [15:0] count_r,  count_nxt;
    logic [15:0] err_r,    err_nxt;
    logic [2:0]  dir_r,    dir_nxt;
    logic        line_r,   line_nxt;
    logic        busy_nxt;
    logic        done_r,   done_nxt;
    logic        pv_r,     pv_nxt;
    logic [15:0] px_r,     px_nxt;
    logic [15:0] py_r,     py_nxt;
    logic [15:0] psx_r,    psx_nxt;
    logic [15:0] psy_r,    psy_nxt;
    logic [15:0] lx;
    logic [15:0] ly;
    logic [15:0] lerr;

    bvp_line_step u_line_step (
        .cur_x_i   (cur_x_r),
        .cur_y_i   (cur_y_r),
        .err_i     (err_r),
        .axial_i   (cur_sx_r),
        .diag_i    (cur_sy_r),
        .y_major_i (dir_r[`BVP_MODE_YMAJ]),
        .x_neg_i   (dir_r[`BVP_MODE_XNEG]),
        .y_neg_i   (dir_r[`BVP_MODE_YNEG]),
        .nxt_x_o   (lx),
        .nxt_y_o   (ly),
        .nxt_err_o (lerr)
    );

    always_comb begin
        state_nxt  = state_r;
        cur_x_nxt  = cur_x_r;
        cur_y_nxt  = cur_y_r;
        cur_sx_nxt = cur_sx_r;
        cur_sy_nxt = cur_sy_r;
        org_x_nxt  = org_x_r;
        org_sx_nxt = org_sx_r;
        width_nxt  = width_r;
        height_nxt = height_r;
        col_nxt    = col_r;
        row_nxt    = row_r;
        count_nxt  = count_r;
        err_nxt    = err_r;
        dir_nxt    = dir_r;
        line_nxt   = line_r;
        pv_nxt     = 1'b0;
        px_nxt     = px_r;
        py_nxt     = py_r;
        psx_nxt    = psx_r;
        psy_nxt    = psy_r;
        unique case (state_r)
            bvp_pkg::BVP_IDLE: begin
                cur_x_nxt = origin_r[`BVP_LO_MSB:`BVP_LO_LSB];
                cur_y_nxt = origin_r[`BVP_HI_MSB:`BVP_HI_LSB];
                org_x_nxt = origin_r[`BVP_LO_MSB:`BVP_LO_LSB];
                col_nxt   = `BVP_RST_HALF;
                row_nxt   = `BVP_RST_HALF;
                if (start_block) begin
                    line_nxt   = 1'b0;
                    cur_sx_nxt = source_r[`BVP_HI_MSB:`BVP_HI_LSB];
                    org_sx_nxt = source_r[`BVP_HI_MSB:`BVP_HI_LSB];
                    cur_sy_nxt = source_r[`BVP_LO_MSB:`BVP_LO_LSB];
                    width_nxt  = size_r[`BVP_HI_MSB:`BVP_HI_LSB];
                    height_nxt = size_r[`BVP_LO_MSB:`BVP_LO_LSB];
                    if (size_r[`BVP_HI_MSB:`BVP_HI_LSB] == `BVP_RST_HALF ||
                        size_r[`BVP_LO_MSB:`BVP_LO_LSB] == `BVP_RST_HALF)
                    begin
                        state_nxt = bvp_pkg::BVP_DONE;
                    end else begin
                        state_nxt = bvp_pkg::BVP_RUN;
                    end
                end else if (start_line) begin
                    line_nxt   = 1'b1;
                    cur_sx_nxt = source_r[`BVP_HI_MSB:`BVP_HI_LSB];
                    cur_sy_nxt = source_r[`BVP_LO_MSB:`BVP_LO_LSB];
                    err_nxt    = size_r[`BVP_LO_MSB:`BVP_LO_LSB];
                    count_nxt  = {`BVP_LEN_PAD,
                                  size_r[`BVP_LEN_MSB:`BVP_LEN_LSB]};
                    dir_nxt    = reg_wdata_i[2:0];
                    if (size_r[`BVP_LEN_MSB:`BVP_LEN_LSB] == 14'h0000) begin
                        state_nxt = bvp_pkg::BVP_DONE;
                    end else begin
                        state_nxt = bvp_pkg::BVP_RUN;
                    end
                end
            end
            bvp_pkg::BVP_RUN: begin
                pv_nxt  = 1'b1;
                px_nxt  = cur_x_r;
                py_nxt  = cur_y_r;
                psx_nxt = line_r ? `BVP_RST_HALF : cur_sx_r;
                psy_nxt = line_r ? `BVP_RST_HALF : cur_sy_r;
                if (line_r) begin
                    cur_x_nxt = lx;
                    cur_y_nxt = ly;
                    err_nxt   = lerr;
                    count_nxt = count_r - 16'h0001;
                    if (count_r == 16'h0001) begin
                        state_nxt = bvp_pkg::BVP_DONE;
                    end
                end else if (col_r == width_r - 16'h0001) begin
                    col_nxt    = `BVP_RST_HALF;
                    row_nxt    = row_r + 16'h0001;
                    cur_x_nxt  = org_x_r;
                    cur_sx_nxt = org_sx_r;
                    cur_y_nxt  = bvp_pkg::bvp_step(cur_y_r, 1'b0);
                    cur_sy_nxt = bvp_pkg::bvp_step(cur_sy_r, 1'b0);
                    if (row_r == height_r - 16'h0001) begin
                        state_nxt = bvp_pkg::BVP_DONE;
                    end
                end else begin
                    col_nxt    = col_r + 16'h0001;
                    cur_x_nxt  = bvp_pkg::bvp_step(cur_x_r, 1'b0);
                    cur_sx_nxt = bvp_pkg::bvp_step(cur_sx_r, 1'b0);
                end
            end
            bvp_pkg::BVP_DONE: begin
                state_nxt = bvp_pkg::BVP_IDLE;
            end
            default: begin
                state_nxt = bvp_pkg::BVP_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != bvp_pkg::BVP_IDLE);
        done_nxt = (state_nxt == bvp_pkg::BVP_DONE);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r  <= bvp_pkg::BVP_IDLE;
            cur_x_r  <= `BVP_RST_HALF;
            cur_y_r  <= `BVP_RST_HALF;
            cur_sx_r <= `BVP_RST_HALF;
            cur_sy_r <= `BVP_RST_HALF;
            org_x_r  <= `BVP_RST_HALF;
            org_sx_r <= `BVP_RST_HALF;
            width_r  <= `BVP_RST_HALF;
            height_r <= `BVP_RST_HALF;
            col_r    <= `BVP_RST_HALF;
            row_r    <= `BVP_RST_HALF;
            count_r  <= `BVP_RST_HALF;
            err_r    <= `BVP_RST_HALF;
            dir_r    <= 3'h0;
            line_r   <= 1'b0;
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            pv_r     <= 1'b0;
            px_r     <= `BVP_RST_HALF;
            py_r     <= `BVP_RST_HALF;
            psx_r    <= `BVP_RST_HALF;
            psy_r    <= `BVP_RST_HALF;
        end else begin
            state_r  <= state_nxt;
            cur_x_r  <= cur_x_nxt;
            cur_y_r  <= cur_y_nxt;
            cur_sx_r <= cur_sx_nxt;
            cur_sy_r <= cur_sy_nxt;
            org_x_r  <= org_x_nxt;
            org_sx_r <= org_sx_nxt;
            width_r  <= width_nxt;
            height_r <= height_nxt;
            col_r    <= col_nxt;
            row_r    <= row_nxt;
            count_r  <= count_nxt;
            err_r    <= err_nxt;
            dir_r    <= dir_nxt;
            line_r   <= line_nxt;
            busy_r   <= busy_nxt;
            done_r   <= done_nxt;
            pv_r     <= pv_nxt;
            px_r     <= px_nxt;
            py_r     <= py_nxt;
            psx_r    <= psx_nxt;
            psy_r    <= psy_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    always_comb begin
        reg_rdata_o    = rdata_r;
        reg_rvalid_o   = rvalid_r;
        legacy_base_o  = legacy_base_r;
        legacy_latch_o = latch_r;
        colour_clear_o = colour_r[`BVP_HI_MSB:`BVP_HI_LSB];
        colour_set_o   = colour_r[`BVP_LO_MSB:`BVP_LO_LSB];
        busy_o         = busy_r;
        op_line_o      = line_r;
        op_done_o      = done_r;
        pix_valid_o    = pv_r;
        pix_x_o        = px_r;
        pix_y_o        = py_r;
        pix_src_x_o    = psx_r;
        pix_src_y_o    = psy_r;
    end

endmodule : bvp_top

//--- common/bvp_regs.svh
`ifndef BVP_REGS_SVH
`define BVP_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets from the register window base.
// ----------------------------------------------------------------------
`define BVP_OFS_ORIGIN      16'h8100
`define BVP_OFS_SIZE        16'h8104
`define BVP_OFS_SOURCE      16'h8108
`define BVP_OFS_COLOUR      16'h810c
`define BVP_OFS_LINE_TRIG   16'h8204
`define BVP_OFS_BLOCK_TRIG  16'h8208
`define BVP_OFS_STATUS      16'h820c
`define BVP_OFS_LEGACY_BASE 16'h8210
`define BVP_OFS_LEGACY_LAT  16'h8214

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define BVP_RST_WORD        32'h0000_0000
`define BVP_RST_HALF        16'h0000

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define BVP_HI_MSB          31
`define BVP_HI_LSB          16
`define BVP_LO_MSB          15
`define BVP_LO_LSB          0
`define BVP_LEN_MSB         29
`define BVP_LEN_LSB         16
`define BVP_LEN_PAD         2'h0
`define BVP_ST_BUSY         0
`define BVP_ST_LINE         1
`define BVP_ST_DROP         2
`define BVP_ST_PAD          5'h00
`define BVP_ST_CFG_MSB      31
`define BVP_ST_CFG_LSB      8
`define BVP_MODE_YMAJ       0
`define BVP_MODE_XNEG       1
`define BVP_MODE_YNEG       2

`endif

//--- common/bvp_pkg.sv
package bvp_pkg;

    // ------------------------------------------------------------------
    // Engine sequence states.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BVP_IDLE = 2'h0,
        BVP_RUN  = 2'h1,
        BVP_DONE = 2'h3
    } bvp_state_t;

    typedef logic [15:0] bvp_half_t;

    // Moves a coordinate one pixel up or down.
    function automatic bvp_half_t bvp_step(input bvp_half_t v,
                                           input logic      neg);
        bvp_step = neg ? v - 16'h0001 : v + 16'h0001;
    endfunction : bvp_step

endpackage : bvp_pkg

//--- rtl/bvp_line_step.sv
`timescale 1ns/100ps

module bvp_line_step (
    // Current point and error terms
    input  wire logic [15:0] cur_x_i,
    input  wire logic [15:0] cur_y_i,
    input  wire logic [15:0] err_i,
    input  wire logic [15:0] axial_i,
    input  wire logic [15:0] diag_i,
    // Direction
    input  wire logic        y_major_i,
    input  wire logic        x_neg_i,
    input  wire logic        y_neg_i,
    // Next point
    output logic      [15:0] nxt_x_o,
    output logic      [15:0] nxt_y_o,
    output logic      [15:0] nxt_err_o
);

    logic diag_move;

    always_comb begin
        diag_move = ~err_i[15];
        if (diag_move) begin
            nxt_err_o = err_i + diag_i;
        end else begin
            nxt_err_o = err_i + axial_i;
        end
        if (!y_major_i || diag_move) begin
            nxt_x_o = bvp_pkg::bvp_step(cur_x_i, x_neg_i);
        end else begin
            nxt_x_o = cur_x_i;
        end
        if (y_major_i || diag_move) begin
            nxt_y_o = bvp_pkg::bvp_step(cur_y_i, y_neg_i);
        end else begin
            nxt_y_o = cur_y_i;
        end
    end

endmodule : bvp_line_step

//--- sim/bvp_top_sva.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Port checker for the parameter register block.
// ----------------------------------------------------------------------
module bvp_chk (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    // Register access
    input wire logic [15:0] reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    // Legacy latch inputs and outputs, colour outputs
    input wire logic        latch_load_i,
    input wire logic [31:0] latch_data_i,
    input wire logic [31:0] legacy_latch_o,
    input wire logic [15:0] colour_clear_o,
    input wire logic [15:0] colour_set_o,
    // Engine
    input wire logic        busy_o,
    input wire logic        op_done_o,
    input wire logic        pix_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence trig_idle_s;
        reg_wr_i && !busy_o &&
        (reg_addr_i == 16'h8204 || reg_addr_i == 16'h8208);
    endsequence
    sequence colour_wr_s;
        reg_wr_i && reg_addr_i == 16'h810c;
    endsequence

    read_resp_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read without answer");
    no_spur_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("answer without read");
    unmapped_zero_a: assert property (
        reg_rd_i && reg_addr_i[15:8] == 8'h83 |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    trig_start_a: assert property (trig_idle_s |=> busy_o)
        else $error("trigger did not start engine");
    param_quiet_a: assert property (
        !busy_o && !(reg_wr_i && (reg_addr_i == 16'h8204 ||
        reg_addr_i == 16'h8208)) |=> !busy_o)
        else $error("engine started without trigger");
    pix_busy_a: assert property (pix_valid_o |-> busy_o)
        else $error("pixel while idle");
    done_ends_a: assert property (
        op_done_o |=> !busy_o && !pix_valid_o)
        else $error("engine active after done");
    latch_load_a: assert property (
        latch_load_i |=> legacy_latch_o == $past(latch_data_i))
        else $error("latch load lost");
    colour_split_a: assert property (colour_wr_s |=>
        colour_clear_o == $past(reg_wdata_i[31:16]) &&
        colour_set_o == $past(reg_wdata_i[15:0]))
        else $error("colour halves wrong");
endmodule : bvp_chk

bind bvp_top bvp_chk chk_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .latch_load_i(latch_load_i), .latch_data_i(latch_data_i),
    .legacy_latch_o(legacy_latch_o), .colour_clear_o(colour_clear_o),
    .colour_set_o(colour_set_o), .busy_o(busy_o),
    .op_done_o(op_done_o), .pix_valid_o(pix_valid_o)
);

//--- sim/blit_vector_param_regs_tb.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Self-checking bench for the parameter register block.
// ----------------------------------------------------------------------
module blit_vector_param_regs_tb;
    typedef struct {logic [15:0] a; logic [31:0] d, e;} bvp_row_t;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0, latch_load_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0;
    logic [31:0] reg_wdata_i = 32'h0, latch_data_i = 32'h0;
    logic [31:0] reg_rdata_o, legacy_base_o, legacy_latch_o;
    logic [15:0] colour_clear_o, colour_set_o, pix_x_o, pix_y_o;
    logic [15:0] pix_src_x_o, pix_src_y_o;
    logic        reg_rvalid_o, busy_o, op_line_o, op_done_o, pix_valid_o;
    int          comparisons = 0, n_fail = 0, nd = 0;
    logic [63:0] pq[$];
    bvp_row_t    rows[8] = '{
        '{16'h8100, 32'ha5a5_0001, 32'ha5a5_0001},
        '{16'h8104, 32'h8000_7fff, 32'h8000_7fff},
        '{16'h8108, 32'h1234_fedc, 32'h1234_fedc},
        '{16'h810c, 32'h4242_1717, 32'h4242_1717},
        '{16'h820c, 32'habcd_12ff, 32'habcd_1200},
        '{16'h8210, 32'h0bad_f00d, 32'h0bad_f00d},
        '{16'h8214, 32'h5a5a_c3c3, 32'h5a5a_c3c3},
        '{16'h8300, 32'hffff_ffff, 32'h0000_0000}};
    logic [31:0] zsz[3] = '{32'h0000_0005, 32'h0005_0000, 32'hc000_0000};
    logic [15:0] ztr[3] = '{16'h8208, 16'h8208, 16'h8204};

    bvp_top dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .latch_load_i(latch_load_i), .latch_data_i(latch_data_i),
        .legacy_base_o(legacy_base_o), .legacy_latch_o(legacy_latch_o),
        .colour_clear_o(colour_clear_o), .colour_set_o(colour_set_o),
        .busy_o(busy_o), .op_line_o(op_line_o), .op_done_o(op_done_o),
        .pix_valid_o(pix_valid_o), .pix_x_o(pix_x_o), .pix_y_o(pix_y_o),
        .pix_src_x_o(pix_src_x_o), .pix_src_y_o(pix_src_y_o));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (pix_valid_o === 1'b1) begin
            pq.push_back({pix_x_o, pix_y_o, pix_src_x_o, pix_src_y_o});
        end
        if (op_done_o === 1'b1) begin
            nd++;
        end
    end

    task automatic chk(input string nm, input logic [63:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        chk("rvalid", 64'h1, {63'h0, reg_rvalid_o});
        chk("rdata", {32'h0, e}, {32'h0, reg_rdata_o});
    endtask : rd

    task automatic run(input logic [15:0] t, input logic [31:0] d);
        pq.delete();
        nd = 0;
        wr(t, d);
        for (int k = 0; k < 40 && nd == 0; k++) begin
            @(negedge clk_i);
        end
        repeat (3) @(negedge clk_i);
        chk("op_done", 64'h1, 64'(nd));
    endtask : run

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    initial begin
        #1_000_000;
        n_fail++;
        close_out();
    end

    initial begin
        repeat (5) @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(16'h8100 + 16'(i * 4), 32'h0);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk("colour", 64'h42421717, {colour_clear_o, colour_set_o});
        chk("base", 64'h0bad_f00d, {32'h0, legacy_base_o});
        chk("idle", 64'h0, 64'(nd + busy_o));
        wr(16'h8100, 32'h0007_0005);
        wr(16'h8104, 32'h0002_0001);
        wr(16'h8108, 32'h0003_0004);
        run(16'h8208, 32'h0);
        chk("npix", 64'h2, 64'(pq.size()));
        chk("pix0", {16'h5, 16'h7, 16'h3, 16'h4}, pq[0]);
        chk("pix1", {16'h6, 16'h7, 16'h4, 16'h4}, pq[1]);
        wr(16'h8104, 32'h0003_0002);
        wr(16'h8208, 32'h0);
        run(16'h8208, 32'h0);
        chk("nrect", 64'h6, 64'(pq.size()));
        rd(16'h820c, 32'habcd_1204);
        wr(16'h820c, 32'habcd_1204);
        rd(16'h820c, 32'habcd_1200);
        for (int i = 0; i < 3; i++) begin
            wr(16'h8104, zsz[i]);
            run(ztr[i], 32'h0);
            chk("zero", 64'h0, 64'(pq.size()));
        end
        wr(16'h8100, 32'h0001_0001);
        wr(16'h8104, 32'h0003_0000);
        wr(16'h8108, 32'h0001_fffe);
        run(16'h8204, 32'h0);
        chk("nline", 64'h3, 64'(pq.size()));
        chk("lpix0", {16'h1, 16'h1, 32'h0}, pq[0]);
        chk("line", 64'h1, {63'h0, op_line_o});
        chk("lpix1", {16'h2, 16'h2, 32'h0}, pq[1]);
        chk("lpix2", {16'h3, 16'h2, 32'h0}, pq[2]);
        run(16'h8204, 32'h7);
        chk("nvec", 64'h3, 64'(pq.size()));
        chk("vpix0", {16'h1, 16'h1, 32'h0}, pq[0]);
        chk("vpix1", {16'h0, 16'h0, 32'h0}, pq[1]);
        chk("vpix2", {16'h0, 16'hffff, 32'h0}, pq[2]);
        rd(16'h820c, 32'habcd_1202);
        @(negedge clk_i);
        latch_load_i = 1'b1;
        latch_data_i = 32'h1357_9bdf;
        @(negedge clk_i);
        latch_load_i = 1'b0;
        rd(16'h8214, 32'h1357_9bdf);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        rd(16'h8104, 32'h0);
        rd(16'h820c, 32'h0);
        close_out();
    end
endmodule : blit_vector_param_regs_tb
